// ---- pce_pkg.sv ----
// Package with register map, field positions and carriers for the counter enable block.
package pce_pkg;
	localparam int unsigned NUM_EVT = 4;
	localparam int unsigned EVT_CODE_W = 10;
	localparam int unsigned CNT_W = 32;
	localparam logic [11:0] OFF_CONTROL = 12'h000;
	localparam logic [11:0] OFF_ENABLE_SET = 12'h004;
	localparam logic [11:0] OFF_ENABLE_CLEAR = 12'h008;
	localparam logic [11:0] OFF_CYCLE_COUNTER = 12'h00c;
	localparam logic [11:0] OFF_EVENT_COUNTER = 12'h010;
	localparam logic [11:0] OFF_EVENT_TYPE = 12'h020;
	localparam int unsigned CYCLE_EN_BIT = 31;
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_EVT_RST_BIT = 1;
	localparam int unsigned CTRL_CYC_RST_BIT = 2;
	localparam logic [EVT_CODE_W-1:0] EVT_NONE = 10'h000;
	localparam logic [EVT_CODE_W-1:0] EVT_CYCLE = 10'h011;
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
	localparam logic [31:0] ENABLE_MASK = 32'h8000_000f;
	typedef struct packed {
		logic cycle;
		logic [NUM_EVT-1:0] evt;
	} pce_enable_s;
endpackage

// ---- pce_counter_enable.sv ----
// Count-enable set and clear registers with the cycle and event counters they steer.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module pce_counter_enable #(
	parameter int unsigned NUM_EVT = pce_pkg::NUM_EVT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1023:0] event_in,
	output logic [NUM_EVT-1:0] counting
);
	pce_pkg::pce_enable_s en_reg, en_next;
	logic glob_en_reg, glob_en_next;
	logic [31:0] cyc_reg, cyc_next;
	logic [31:0] evc_reg [NUM_EVT];
	logic [31:0] evc_next [NUM_EVT];
	logic [9:0] sel_reg [NUM_EVT];
	logic [9:0] sel_next [NUM_EVT];
	logic [31:0] prdata_next;
	logic pslverr_next;
	logic setup, wr, rd_setup, hit;
	logic wr_ctrl, wr_set, wr_clr;
	logic evt_rst, cyc_rst;
	logic [31:0] en_word;
	logic [31:0] rd_word;

	// Writes land at the access edge. Read data and the error flag are loaded at the
	// setup edge, so both already stand while the master samples them with zero waits.
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign rd_setup = setup && !pwrite;
	assign pready = 1'b1;
	assign wr_ctrl = wr && (paddr == pce_pkg::OFF_CONTROL);
	assign wr_set = wr && (paddr == pce_pkg::OFF_ENABLE_SET);
	assign wr_clr = wr && (paddr == pce_pkg::OFF_ENABLE_CLEAR);

	// Counter resets are one-cycle pulses, so the control register reads them as zero.
	assign evt_rst = wr_ctrl && pwdata[pce_pkg::CTRL_EVT_RST_BIT];
	assign cyc_rst = wr_ctrl && pwdata[pce_pkg::CTRL_CYC_RST_BIT];

	// Enable state as a register word; bits 30 to 4 are tied to zero.
	assign en_word = {en_reg.cycle, 27'h0, en_reg.evt};

	// Enable group: the set and clear registers edit one shared state.
	always_comb begin
		en_next = en_reg;
		glob_en_next = glob_en_reg;
		if (wr_ctrl) begin
			glob_en_next = pwdata[pce_pkg::CTRL_EN_BIT];
		end
		if (wr_set) begin
			// Only ones take effect, so set and clear edit the same flops.
			en_next.cycle = en_reg.cycle | pwdata[pce_pkg::CYCLE_EN_BIT];
			en_next.evt = en_reg.evt | pwdata[NUM_EVT-1:0];
		end
		if (wr_clr) begin
			en_next.cycle = en_reg.cycle & ~pwdata[pce_pkg::CYCLE_EN_BIT];
			en_next.evt = en_reg.evt & ~pwdata[NUM_EVT-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg <= '0;
			glob_en_reg <= 1'b0;
		end else begin
			en_reg <= en_next;
			glob_en_reg <= glob_en_next;
		end
	end

	// Read decode; an address that nothing claims leaves hit low.
	always_comb begin
		rd_word = 32'h0;
		hit = 1'b0;
		if (paddr == pce_pkg::OFF_CONTROL) begin
			hit = 1'b1;
			rd_word = {31'h0, glob_en_reg};
		end else if (paddr == pce_pkg::OFF_ENABLE_SET) begin
			hit = 1'b1;
			rd_word = en_word;
		end else if (paddr == pce_pkg::OFF_ENABLE_CLEAR) begin
			hit = 1'b1;
			rd_word = en_word;
		end else if (paddr == pce_pkg::OFF_CYCLE_COUNTER) begin
			hit = 1'b1;
			rd_word = cyc_reg;
		end else begin
			for (int k = 0; k < NUM_EVT; k++) begin
				if (paddr == pce_pkg::OFF_EVENT_COUNTER + 12'(4 * k)) begin
					hit = 1'b1;
					rd_word = evc_reg[k];
				end
				if (paddr == pce_pkg::OFF_EVENT_TYPE + 12'(4 * k)) begin
					hit = 1'b1;
					rd_word = {22'h0, sel_reg[k]};
				end
			end
		end
	end

	// Selector writes; only the low code bits are kept.
	always_comb begin
		for (int k = 0; k < NUM_EVT; k++) begin
			sel_next[k] = sel_reg[k];
			if (wr && (paddr == pce_pkg::OFF_EVENT_TYPE + 12'(4 * k))) begin
				sel_next[k] = pwdata[pce_pkg::EVT_CODE_W-1:0];
			end
		end
	end

	// Bus response group. An unmapped write is not decoded, so it is dropped, but like an unmapped read it still raises pslverr.
	always_comb begin
		prdata_next = prdata;
		pslverr_next = 1'b0;
		if (rd_setup) begin
			prdata_next = rd_word;
		end
		if (setup && !hit) begin
			pslverr_next = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			prdata <= prdata_next;
			pslverr <= pslverr_next;
		end
	end

	// Cycle counter group; a reset pulse wins over a same-cycle increment.
	always_comb begin
		cyc_next = cyc_reg;
		if (glob_en_reg && en_reg.cycle) begin
			cyc_next = cyc_reg + 32'h1;
		end
		if (cyc_rst) begin
			cyc_next = 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc_reg <= 32'h0;
		end else begin
			cyc_reg <= cyc_next;
		end
	end

	// One slice per event counter, each with its own selector.
	for (genvar g = 0; g < NUM_EVT; g++) begin : g_evt
		logic evt_hit;

		assign counting[g] = glob_en_reg && en_reg.evt[g];
		// Code zero never counts, even if its event line happens to be high.
		assign evt_hit = (sel_reg[g] != pce_pkg::EVT_NONE) &&
			((sel_reg[g] == pce_pkg::EVT_CYCLE) || event_in[sel_reg[g]]);

		always_comb begin
			evc_next[g] = evc_reg[g];
			if (counting[g] && evt_hit) begin
				evc_next[g] = evc_reg[g] + 32'h1;
			end
			// The reset wins, so an enabled counter resumes from zero.
			if (evt_rst) begin
				evc_next[g] = 32'h0;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				evc_reg[g] <= 32'h0;
				sel_reg[g] <= 10'h0;
			end else begin
				evc_reg[g] <= evc_next[g];
				sel_reg[g] <= sel_next[g];
			end
		end
	end
endmodule

// ---- pce_monitor.sv ----
// Port checks for the counter enable block.
`timescale 1ns/1ns
module pce_monitor #(
	parameter int unsigned NUM_EVT = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [NUM_EVT-1:0] counting
);
	wire acc = psel && penable;
	wire clr = acc && pwrite && paddr == 12'h008;
	wire rd = acc && !pwrite && (paddr == 12'h004 || paddr == 12'h008);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	clr_hits_a: assert property (clr |=> (counting & $past(pwdata[3:0])) == 0)
		else $error("clear missed");
	zero_keep_a: assert property (clr |=> (counting | $past(pwdata[3:0])) ==
		($past(counting) | $past(pwdata[3:0]))) else $error("clear hit a zero bit");
	read_live_a: assert property (rd |-> (prdata[3:0] & counting) == counting)
		else $error("read lost an enable");
	rsv_zero_a: assert property (rd |-> prdata[30:4] == 27'h0)
		else $error("reserved bits set");
	reset_idle_a: assert property ($rose(presetn) |-> counting == 0)
		else $error("enabled after reset");
	ctrl_off_a: assert property (acc && pwrite && paddr == 12'h000 && !pwdata[0] |=>
		counting == 0) else $error("counting while off");
	err_map_a: assert property (acc && paddr >= 12'h030 |-> pslverr)
		else $error("no error on unmapped");
	err_ok_a: assert property (acc && paddr < 12'h030 |-> !pslverr)
		else $error("error on mapped");
	cover property (clr);
	cover property (rd);
	cover property (acc && paddr >= 12'h030);
endmodule
bind pce_counter_enable pce_monitor #(.NUM_EVT(NUM_EVT)) mon_u (.*);

// ---- pce_counter_enable_tb_top.sv ----
// Directed testbench for the counter enable block.
`timescale 1ns/1ns
module pce_counter_enable_tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q, x;
	logic [3:0] counting;
	logic e;
	int err_total = 0, checked = 0;
	pce_counter_enable dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .event_in(1024'h0), .counting(counting));
	initial forever #4 pclk = ~pclk;
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) err_total++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic t_set_clear;
		apb(0, 12'h008, 0); chk("reset", 32'h0, q);
		apb(1, 12'h000, 1); apb(1, 12'h004, 32'h8000_000f);
		apb(0, 12'h008, 0); chk("clear read", 32'h8000_000f, q);
		apb(1, 12'h008, 32'h8000_0005); apb(0, 12'h004, 0);
		chk("after clear", 32'h0000_000a, q);
		chk("counting", 32'h0000_000a, {28'h0, counting});
		apb(1, 12'h008, 32'h7fff_fff0); apb(0, 12'h008, 0);
		chk("reserved", 32'h0000_000a, q);
	endtask
	task automatic t_counters;
		apb(1, 12'h024, 32'h11); apb(0, 12'h024, 0); chk("type", 32'h11, q);
		apb(1, 12'h000, 3); repeat (5) @(posedge pclk);
		apb(0, 12'h01c, 0); chk("no event", 32'h0, q);
		apb(1, 12'h000, 0); apb(0, 12'h014, 0); x = q;
		chk("counted", 32'h1, {31'h0, q != 0 && q < 32'h20});
		apb(0, 12'h014, 0); chk("frozen", x, q);
		apb(0, 12'h040, 0); chk("unmapped", 32'h0, q);
		chk("slverr", 32'h1, {31'h0, e});
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_set_clear;
		t_counters;
		end_of_test;
	end
	initial begin
		#100000;
		err_total++;
		end_of_test;
	end
endmodule
